// file: include/eqctl_pkg.sv
package eqctl_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CDR_RST_TIME_NS = 200;
   localparam int CDR_RST_CYC = (CDR_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Pin voltage codes, full scale 8'hff equals io_supply
   localparam logic [7:0] TH_LR = 8'h33;
   localparam logic [7:0] TH_RF = 8'h80;
   localparam logic [7:0] TH_FH = 8'hcc;
   localparam logic [7:0] PIN_OPEN_CODE = 8'haa;
   localparam logic [1:0] LVL_L = 2'h0;
   localparam logic [1:0] LVL_R = 2'h1;
   localparam logic [1:0] LVL_F = 2'h2;
   localparam logic [1:0] LVL_H = 2'h3;
   localparam logic [2:0] RATE_11G88 = 3'h0;
   localparam logic [2:0] RATE_5G94 = 3'h1;
   localparam logic [2:0] RATE_2G97 = 3'h2;
   localparam logic [2:0] RATE_1G485 = 3'h3;
   localparam logic [2:0] RATE_270M = 3'h4;
   localparam logic [2:0] RATE_125M = 3'h5;
   localparam logic [2:0] RATE_10G3125 = 3'h6;
   localparam logic [2:0] RATE_1G25 = 3'h7;
   // Word indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL = 10'h000;
   localparam logic [9:0] IDX_BOOST = 10'h001;
   localparam logic [9:0] IDX_STATUS = 10'h002;
   localparam logic [9:0] IDX_TABLE = 10'h040;
   localparam int TABLE_LEN = 16;
   localparam int CTRL_W = 11;
   localparam int C_PATH_OVR = 0;
   localparam int C_PATH_LVL = 1;
   localparam int C_RATE_OVR = 3;
   localparam int C_RATE_SMPTE = 4;
   localparam int C_SPLIT = 5;
   localparam int C_BYP_OVR = 6;
   localparam int C_BYP_VAL = 7;
   localparam int C_FIXED = 8;
   localparam int C_SUBRATE = 9;
   localparam int C_CDR_RST = 10;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
   localparam logic [7:0] FIXED_BOOST_RST = 8'h00;
   localparam logic [7:0] LOW_BOOST_RST = 8'h00;
   localparam int B_FIXED = 0;
   localparam int B_LOW = 8;

   typedef enum logic [1:0] {A_IDLE, A_STEP, A_DONE} adapt_st_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic sel_trace;
      logic first_out_en;
      logic second_out_en;
      logic second_out_clock;
      logic coax_eq_pwr;
      logic trace_eq_pwr;
      logic eq_bypass;
      logic coax_adapt_en;
      logic auto_adapt_mode;
      logic fixed_boost_mode;
      logic [7:0] trace_boost;
      logic splitter_mode;
      logic power_save;
      logic rate_smpte;
      logic cdr_bypass;
      logic sub_rate_en;
      logic cdr_reset;
   } path_ctl_t;
endpackage : eqctl_pkg

// file: hw/sdi_equalizer_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
module sdi_equalizer_mode_control
   import eqctl_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire apb_req_t apb_req,
   output apb_rsp_t apb_rsp,
   input wire logic [7:0] path_pin_code,
   input wire logic [7:0] outfn_pin_code,
   input wire logic cd_coax,
   input wire logic cd_trace,
   input wire logic cdr_lock,
   input wire logic [2:0] rate_code,
   input wire logic [7:0] eye_quality,
   output path_ctl_t ctl,
   output logic lock_n_out,
   output logic lock_n_oe
);

   generate
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
         $error("SETTLE_CYCLES must be 1 to 255");
      end
   endgenerate

   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
   localparam logic [7:0] RST_LOAD = 8'(CDR_RST_CYC);

   typedef struct packed {
      logic [7:0] path_s1;
      logic [7:0] path_s2;
      logic [7:0] outfn_s1;
      logic [7:0] outfn_s2;
      logic [5:0] misc_s1;
      logic [5:0] misc_s2;
      logic [CTRL_W-1:0] ctrl;
      logic [7:0] fixed_boost;
      logic [7:0] low_boost;
      logic [TABLE_LEN-1:0][7:0] table_val;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      adapt_st_t a_st;
      logic [3:0] idx;
      logic [3:0] best_idx;
      logic [7:0] best_q;
      logic [7:0] settle;
      logic fam_prev;
      logic carrier_prev;
      logic rst_pend;
      logic [7:0] rst_cnt;
      path_ctl_t ctl;
      logic lock_oe;
      logic lock_level;
   } state_t;

   state_t st;
   state_t next_st;

   function automatic logic [1:0] decode_level(input logic [7:0] v);
      if (v < TH_LR) begin
         return LVL_L;
      end else if (v < TH_RF) begin
         return LVL_R;
      end else if (v < TH_FH) begin
         return LVL_F;
      end
      return LVL_H;
   endfunction : decode_level

   function automatic logic reg_hit(input logic [9:0] idx);
      return idx == IDX_CTRL || idx == IDX_BOOST || idx == IDX_STATUS ||
         (idx >= IDX_TABLE && idx < IDX_TABLE + 10'(TABLE_LEN));
   endfunction : reg_hit

   logic [1:0] pin_path;
   logic [1:0] pin_outfn;
   logic [1:0] path_lvl;
   logic sel_trace;
   logic carrier;
   logic [2:0] rate;
   logic rate_smpte;
   logic adaptable;
   logic lowrate;
   logic eq_bypass;
   logic cdr_bypass;
   logic auto_cond;
   logic lock_ok;
   logic [9:0] widx;
   logic [3:0] tsel;
   logic access;

   always_comb begin
      next_st = st;
      next_st.path_s1 = path_pin_code;
      next_st.path_s2 = st.path_s1;
      next_st.outfn_s1 = outfn_pin_code;
      next_st.outfn_s2 = st.outfn_s1;
      next_st.misc_s1 = {rate_code, cdr_lock, cd_trace, cd_coax};
      next_st.misc_s2 = st.misc_s1;

      pin_path = decode_level(st.path_s2);
      pin_outfn = decode_level(st.outfn_s2);
      path_lvl = st.ctrl[C_PATH_OVR] ? st.ctrl[C_PATH_LVL +: 2] : pin_path;
      sel_trace = (path_lvl == LVL_R) || (path_lvl == LVL_L);
      carrier = sel_trace ? st.misc_s2[1] : st.misc_s2[0];
      rate = st.misc_s2[5:3];
      rate_smpte = st.ctrl[C_RATE_OVR] ? st.ctrl[C_RATE_SMPTE] : !sel_trace;
      adaptable = rate == RATE_11G88 || rate == RATE_5G94 || rate == RATE_2G97 ||
         rate == RATE_10G3125;
      lowrate = rate == RATE_1G485 || rate == RATE_270M;
      eq_bypass = st.ctrl[C_BYP_OVR] ? st.ctrl[C_BYP_VAL] : (pin_outfn == LVL_H);
      cdr_bypass = pin_outfn == LVL_H || pin_outfn == LVL_L ||
         rate == RATE_125M || rate == RATE_1G25;
      auto_cond = sel_trace && carrier && !st.ctrl[C_FIXED] && adaptable && !eq_bypass;
      lock_ok = st.misc_s2[2] && !cdr_bypass && carrier;

      // Trace boost search over the stored table
      case (st.a_st)
         A_IDLE: begin
            if (auto_cond) begin
               next_st.a_st = A_STEP;
               next_st.idx = 4'h0;
               next_st.best_idx = 4'h0;
               next_st.best_q = 8'h00;
               next_st.settle = 8'h00;
            end
         end
         A_STEP: begin
            if (!auto_cond) begin
               next_st.a_st = A_IDLE;
            end else if (st.settle != SETTLE_LAST) begin
               next_st.settle = st.settle + 8'h01;
            end else begin
               next_st.settle = 8'h00;
               if (eye_quality > st.best_q || st.idx == 4'h0) begin
                  next_st.best_q = eye_quality;
                  next_st.best_idx = st.idx;
               end
               if (st.idx == 4'hf) begin
                  next_st.a_st = A_DONE;
               end else begin
                  next_st.idx = st.idx + 4'h1;
               end
            end
         end
         A_DONE: begin
            if (!auto_cond) begin
               next_st.a_st = A_IDLE;
            end
         end
         default: begin
            next_st.a_st = A_IDLE;
         end
      endcase
      tsel = (st.a_st == A_DONE) ? st.best_idx : st.idx;

      // Automatic CDR reset when carrier returns on a new rate family
      next_st.carrier_prev = carrier;
      if (carrier) begin
         next_st.fam_prev = rate_smpte;
      end
      if (carrier && !st.carrier_prev && st.rst_pend) begin
         next_st.rst_pend = 1'b0;
         next_st.rst_cnt = RST_LOAD;
      end else begin
         if (!carrier && rate_smpte != st.fam_prev) begin
            next_st.rst_pend = 1'b1;
         end
         if (st.rst_cnt != 8'h00) begin
            next_st.rst_cnt = st.rst_cnt - 8'h01;
         end
      end

      next_st.ctl.sel_trace = sel_trace;
      next_st.ctl.first_out_en = path_lvl != LVL_R;
      next_st.ctl.second_out_en = path_lvl != LVL_F;
      next_st.ctl.second_out_clock = pin_outfn == LVL_R;
      next_st.ctl.power_save = !carrier;
      next_st.ctl.coax_eq_pwr = !sel_trace && carrier;
      next_st.ctl.trace_eq_pwr = sel_trace && carrier;
      next_st.ctl.eq_bypass = eq_bypass;
      next_st.ctl.coax_adapt_en = !sel_trace && carrier && !eq_bypass;
      next_st.ctl.auto_adapt_mode = auto_cond;
      next_st.ctl.fixed_boost_mode = sel_trace && !auto_cond;
      if (auto_cond) begin
         next_st.ctl.trace_boost = st.table_val[tsel];
      end else if (lowrate) begin
         next_st.ctl.trace_boost = st.low_boost;
      end else begin
         next_st.ctl.trace_boost = st.fixed_boost;
      end
      next_st.ctl.splitter_mode = st.ctrl[C_SPLIT] && !sel_trace;
      next_st.ctl.rate_smpte = rate_smpte;
      next_st.ctl.cdr_bypass = cdr_bypass;
      next_st.ctl.sub_rate_en = st.ctrl[C_SUBRATE] && rate_smpte && adaptable &&
         rate != RATE_10G3125 || st.ctrl[C_SUBRATE] && rate == RATE_1G485;
      next_st.ctl.cdr_reset = st.ctrl[C_CDR_RST] || st.rst_cnt != 8'h00;
      next_st.lock_oe = lock_ok;
      next_st.lock_level = 1'b0;

      // APB slave: one wait state, write lands on the completing edge
      access = apb_req.psel && apb_req.penable;
      widx = apb_req.paddr[11:2];
      if (access && !st.pready) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !reg_hit(widx);
         next_st.prdata = 32'h0000_0000;
         if (!apb_req.pwrite) begin
            if (widx == IDX_CTRL) begin
               next_st.prdata = 32'(st.ctrl);
            end else if (widx == IDX_BOOST) begin
               next_st.prdata = {16'h0000, st.low_boost, st.fixed_boost};
            end else if (widx == IDX_STATUS) begin
               next_st.prdata = {16'h0000, rate, st.best_idx, st.a_st == A_DONE,
                  sel_trace, st.misc_s2[2], !carrier, carrier, pin_outfn, pin_path};
            end else if (reg_hit(widx)) begin
               next_st.prdata = {24'h000000, st.table_val[widx[3:0]]};
            end
         end
      end else if (st.pready) begin
         next_st.pready = 1'b0;
         next_st.pslverr = 1'b0;
         if (access && apb_req.pwrite && !st.pslverr) begin
            if (widx == IDX_CTRL) begin
               next_st.ctrl = apb_req.pwdata[CTRL_W-1:0];
            end else if (widx == IDX_BOOST) begin
               next_st.fixed_boost = apb_req.pwdata[B_FIXED +: 8];
               next_st.low_boost = apb_req.pwdata[B_LOW +: 8];
            end else if (widx != IDX_STATUS) begin
               next_st.table_val[widx[3:0]] = apb_req.pwdata[7:0];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.path_s1 <= PIN_OPEN_CODE;
         st.path_s2 <= PIN_OPEN_CODE;
         st.outfn_s1 <= PIN_OPEN_CODE;
         st.outfn_s2 <= PIN_OPEN_CODE;
         st.ctrl <= CTRL_RST;
         st.fixed_boost <= FIXED_BOOST_RST;
         st.low_boost <= LOW_BOOST_RST;
         st.ctl.power_save <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign apb_rsp = '{prdata: st.prdata, pready: st.pready, pslverr: st.pslverr};
   assign ctl = st.ctl;
   assign lock_n_out = st.lock_level;
   assign lock_n_oe = st.lock_oe;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   AST_PIN_L_ROUTE: assert property (!st.ctrl[C_PATH_OVR] && st.path_s2 < TH_LR |=>
      ctl.sel_trace && ctl.first_out_en && ctl.second_out_en)
      else $error("low pin code not decoded as trace to both outputs");
   AST_OPEN_PIN_F: assert property (!st.ctrl[C_PATH_OVR] && st.path_s2 == PIN_OPEN_CODE |=>
      !ctl.sel_trace && ctl.first_out_en && !ctl.second_out_en)
      else $error("open pin code not decoded as F");
   AST_POWER_SAVE: assert property (##1 ctl.power_save == !$past(carrier))
      else $error("power save does not follow carrier");
   AST_NORMAL_MODE: assert property (carrier [*3] |=> !ctl.power_save)
      else $error("carrier present but still in power save");
   AST_SPLIT_COAX: assert property (ctl.splitter_mode |-> !ctl.sel_trace)
      else $error("splitter mode on trace input");
   AST_ONE_EQ: assert property (!(ctl.coax_eq_pwr && ctl.trace_eq_pwr))
      else $error("both equalizers powered");
   AST_REG_BYPASS: assert property (st.ctrl[C_BYP_OVR] && st.ctrl[C_BYP_VAL] |=> ctl.eq_bypass)
      else $error("register bypass ignored");
   AST_COAX_ADAPT: assert property (!sel_trace && carrier && !eq_bypass |=> ctl.coax_adapt_en)
      else $error("coax adaptation not enabled");
   AST_SCAN_END: assert property (st.a_st == A_STEP && st.idx == 4'hf &&
      st.settle == SETTLE_LAST && auto_cond |=> st.a_st == A_DONE)
      else $error("boost search did not finish after last entry");
   AST_LOWRATE_BOOST: assert property (sel_trace && lowrate && !auto_cond |=>
      ctl.trace_boost == $past(st.low_boost))
      else $error("low rate boost not applied");
   AST_COAX_SMPTE: assert property (!sel_trace && !st.ctrl[C_RATE_OVR] |=> ctl.rate_smpte)
      else $error("coax not on SMPTE family");
   AST_CDR_BYPASS: assert property (rate == RATE_125M |=> ctl.cdr_bypass)
      else $error("reclocker not bypassed at 125M");
   AST_NO_SUBRATE_SD: assert property (rate == RATE_270M |=> !ctl.sub_rate_en)
      else $error("sub-rate enabled at 270M");
   AST_AUTO_CDR_RST: assert property (carrier && !st.carrier_prev && st.rst_pend |=>
      ##1 ctl.cdr_reset [*5])
      else $error("automatic CDR reset too short");
   AST_LOCK_FLAG: assert property (lock_ok |=> lock_n_oe && !lock_n_out)
      else $error("lock flag not pulled low");

   // Further checks on the registered controls and the bus answer
   AST_TRACE_10G: assert property (sel_trace && !st.ctrl[C_RATE_OVR] |=>
      !ctl.rate_smpte)
      else $error("trace input not on 10GbE family");
   AST_OVR_PATH: assert property (st.ctrl[C_PATH_OVR] &&
      st.ctrl[C_PATH_LVL +: 2] == LVL_H |=>
      !ctl.sel_trace && ctl.first_out_en && ctl.second_out_en)
      else $error("path override to H not applied");
   AST_OVR_PINS: assert property (st.ctrl[C_PATH_OVR] |=>
      ctl.sel_trace == !$past(st.ctrl[C_PATH_LVL + 1]))
      else $error("path override let the pin through");
   AST_SEL_EQ_OFF: assert property (ctl.sel_trace ? !ctl.coax_eq_pwr : !ctl.trace_eq_pwr)
      else $error("unselected equalizer powered");
   AST_PSAVE_EQ_OFF: assert property (ctl.power_save |->
      !ctl.coax_eq_pwr && !ctl.trace_eq_pwr)
      else $error("equalizer powered in power save");
   AST_SUBRATE_OFF: assert property (rate == RATE_125M || rate == RATE_10G3125 ||
      rate == RATE_1G25 |=> !ctl.sub_rate_en)
      else $error("sub-rate enabled at a rate without it");
   AST_LOW_NO_ADAPT: assert property (lowrate |=> !ctl.auto_adapt_mode)
      else $error("trace adaptation running at a low rate");
   AST_FIXED_BOOST: assert property (st.ctrl[C_FIXED] && !lowrate |=>
      ctl.trace_boost == $past(st.fixed_boost))
      else $error("fixed boost not applied");
   AST_LOCK_DROP: assert property (!lock_ok |=> !lock_n_oe)
      else $error("lock flag held low without lock");
   AST_APB_WAIT: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=>
      apb_rsp.pready)
      else $error("access phase not answered after one wait state");
   AST_APB_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held for more than one cycle");
   AST_SPLIT_REG: assert property (!st.ctrl[C_SPLIT] |=> !ctl.splitter_mode)
      else $error("splitter mode without register request");
   AST_PIN_BYPASS: assert property (!st.ctrl[C_BYP_OVR] && pin_outfn == LVL_H |=>
      ctl.eq_bypass)
      else $error("output function pin bypass ignored");

   // Main scenarios the tests should reach
   COV_SCAN_DONE: cover property (st.a_st == A_STEP ##1 st.a_st == A_DONE);
   COV_PATH_OVR: cover property (st.ctrl[C_PATH_OVR] ##1 !st.ctrl[C_PATH_OVR]);
   COV_AUTO_RST: cover property (carrier && !st.carrier_prev && st.rst_pend);
   COV_WAKE: cover property (ctl.power_save ##1 !ctl.power_save);
   COV_APB_WRITE: cover property (apb_req.psel && apb_req.penable && apb_req.pwrite && st.pready);
endmodule : sdi_equalizer_mode_control
`default_nettype wire

// file: bench/video_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module video_source_model (
   input wire logic pclk,
   input wire logic [1:0] carrier_on,
   input wire logic lock_en,
   input wire logic [2:0] rate,
   input wire logic [7:0] boost,
   input wire logic [7:0] best_boost,
   output logic cd_coax,
   output logic cd_trace,
   output logic cdr_lock,
   output logic [2:0] rate_code,
   output logic [7:0] eye_quality
);
   logic [2:0] lock_cnt;
   assign cd_coax = carrier_on[0];
   assign cd_trace = carrier_on[1];
   assign rate_code = rate;
   // Eye opens only at one boost value, so the search has a single winner
   assign eye_quality = (boost == best_boost) ? 8'hf0 : 8'h10;
   // Slow lock: the reclocker needs four cycles of carrier
   always_ff @(posedge pclk) begin
      if (!lock_en || carrier_on == 2'b00) begin
         lock_cnt <= 3'h0;
      end else if (lock_cnt != 3'h4) begin
         lock_cnt <= lock_cnt + 3'h1;
      end
   end
   assign cdr_lock = (lock_cnt == 3'h4);
endmodule : video_source_model
`default_nettype wire

// file: bench/sdi_equalizer_mode_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module sdi_equalizer_mode_control_tb_top;
   import eqctl_pkg::*;
   localparam int SC = 2;
   localparam logic [63:0] CODES = 64'h0032337f80cbccff;
   localparam logic [15:0] MAP = 16'h75ae;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic [7:0] path_pin = 8'haa;
   logic [7:0] outfn_pin = 8'haa;
   logic [1:0] carrier = 2'b11;
   logic lock_en = 1'b0;
   logic [2:0] rate = RATE_11G88;
   logic cd_coax;
   logic cd_trace;
   logic cdr_lock;
   logic [2:0] rate_code;
   logic [7:0] eye_quality;
   path_ctl_t ctl;
   logic lock_n_out;
   logic lock_n_oe;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int n_checks = 0;

   always #20 pclk = ~pclk;

   sdi_equalizer_mode_control #(.SETTLE_CYCLES(SC)) u_sdi_equalizer_mode_control (
      .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp),
      .path_pin_code(path_pin), .outfn_pin_code(outfn_pin), .cd_coax(cd_coax),
      .cd_trace(cd_trace), .cdr_lock(cdr_lock), .rate_code(rate_code),
      .eye_quality(eye_quality), .ctl(ctl), .lock_n_out(lock_n_out), .lock_n_oe(lock_n_oe)
   );

   video_source_model u_video_source_model (
      .pclk(pclk), .carrier_on(carrier), .lock_en(lock_en), .rate(rate),
      .boost(ctl.trace_boost), .best_boost(8'h55), .cd_coax(cd_coax), .cd_trace(cd_trace),
      .cdr_lock(cdr_lock), .rate_code(rate_code), .eye_quality(eye_quality)
   );

   function automatic logic [3:0] pv();
      pv = {ctl.sel_trace, ctl.first_out_en, ctl.second_out_en, ctl.rate_smpte};
   endfunction : pv

   task settle;
      repeat (6) @(posedge pclk);
   endtask : settle

   task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task wr(input logic [9:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
      settle();
   endtask : wr

   task pin(input logic [7:0] c);
      @(posedge pclk);
      path_pin <= c;
      settle();
   endtask : pin

   task t_reset;
      repeat (3) @(posedge pclk);
      `CHK(ctl.power_save, 1'b1)
      `CHK(lock_n_oe, 1'b0)
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      `CHK(pv(), MAP[11:8])
      apb(1'b0, IDX_CTRL, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, IDX_BOOST, 32'h0);
      `CHK(rd, 32'h0)
   endtask : t_reset

   task t_apb;
      apb(1'b1, 10'h3ff, 32'hffffffff);
      `CHK(err, 1'b1)
      apb(1'b1, IDX_STATUS, 32'hffffffff);
      `CHK(err, 1'b0)
      apb(1'b0, IDX_CTRL, 32'h0);
      `CHK(rd, 32'h0)
   endtask : t_apb

   task t_pins;
      logic [1:0] lvl;
      logic [3:0] m;
      for (int i = 0; i < 8; i++) begin
         lvl = 2'(i / 2);
         m = MAP[lvl * 4 +: 4];
         pin(CODES[63 - i * 8 -: 8]);
         `CHK(pv(), m)
         `CHK({ctl.coax_eq_pwr, ctl.trace_eq_pwr}, {~m[3], m[3]})
         apb(1'b0, IDX_STATUS, 32'h0);
         `CHK(rd[1:0], lvl)
      end
   endtask : t_pins

   task t_override;
      pin(8'h00);
      wr(IDX_CTRL, 32'h7);
      `CHK(pv(), MAP[15:12])
      pin(8'h40);
      `CHK(pv(), MAP[15:12])
      wr(IDX_CTRL, 32'h0);
      `CHK(pv(), MAP[7:4])
   endtask : t_override

   task t_carrier;
      pin(8'haa);
      carrier <= 2'b10;
      settle();
      `CHK({ctl.power_save, ctl.coax_eq_pwr}, 2'b10)
      carrier <= 2'b11;
      settle();
      `CHK({ctl.power_save, ctl.coax_eq_pwr}, 2'b01)
   endtask : t_carrier

   task t_split_bypass;
      wr(IDX_CTRL, 32'h20);
      `CHK(ctl.splitter_mode, 1'b1)
      pin(8'h00);
      `CHK(ctl.splitter_mode, 1'b0)
      pin(8'haa);
      wr(IDX_CTRL, 32'hc0);
      `CHK(ctl.eq_bypass, 1'b1)
      wr(IDX_CTRL, 32'h0);
      outfn_pin <= 8'hff;
      settle();
      `CHK({ctl.eq_bypass, ctl.cdr_bypass}, 2'b11)
      outfn_pin <= 8'h00;
      settle();
      `CHK({ctl.eq_bypass, ctl.cdr_bypass}, 2'b01)
      outfn_pin <= 8'h40;
      settle();
      `CHK({ctl.eq_bypass, ctl.cdr_bypass, ctl.second_out_clock}, 3'b001)
      outfn_pin <= 8'haa;
      settle();
      `CHK({ctl.eq_bypass, ctl.cdr_bypass}, 2'b00)
   endtask : t_split_bypass

   task t_adapt;
      `CHK(ctl.coax_adapt_en, 1'b1)
      for (int i = 0; i < TABLE_LEN; i++) apb(1'b1, IDX_TABLE + 10'(i), 32'(i * 17));
      rate <= RATE_10G3125;
      pin(8'h00);
      repeat (16 * SC + 20) @(posedge pclk);
      `CHK(ctl.auto_adapt_mode, 1'b1)
      `CHK(ctl.trace_boost, 8'h55)
      apb(1'b0, IDX_STATUS, 32'h0);
      `CHK(rd[12:8], 5'h0b)
      apb(1'b1, IDX_BOOST, 32'h3c27);
      wr(IDX_CTRL, 32'h100);
      `CHK({ctl.fixed_boost_mode, ctl.trace_boost}, 9'h127)
      wr(IDX_CTRL, 32'h0);
      rate <= RATE_1G485;
      settle();
      `CHK(ctl.trace_boost, 8'h3c)
   endtask : t_adapt

   task t_rate;
      rate <= RATE_10G3125;
      settle();
      `CHK(ctl.rate_smpte, 1'b0)
      wr(IDX_CTRL, 32'h18);
      `CHK(ctl.rate_smpte, 1'b1)
      wr(IDX_CTRL, 32'h200);
      pin(8'hff);
      for (int r = 0; r < 6; r++) begin
         rate <= 3'(r);
         settle();
         `CHK(ctl.cdr_bypass, 1'(r == 5))
         `CHK(ctl.sub_rate_en, 1'(r < 4))
      end
      wr(IDX_CTRL, 32'h0);
      pin(8'h00);
      rate <= RATE_1G25;
      settle();
      `CHK(ctl.cdr_bypass, 1'b1)
      rate <= RATE_10G3125;
      settle();
      `CHK(ctl.cdr_bypass, 1'b0)
   endtask : t_rate

   task t_cdr;
      int cnt;
      cnt = 0;
      lock_en <= 1'b1;
      settle();
      settle();
      `CHK({lock_n_oe, lock_n_out}, 2'b10)
      wr(IDX_CTRL, 32'h400);
      `CHK(ctl.cdr_reset, 1'b1)
      wr(IDX_CTRL, 32'h0);
      `CHK(ctl.cdr_reset, 1'b0)
      rate <= RATE_11G88;
      pin(8'hff);
      carrier <= 2'b00;
      settle();
      wr(IDX_CTRL, 32'h08);
      carrier <= 2'b11;
      repeat (20) begin
         @(posedge pclk);
         if (ctl.cdr_reset === 1'b1) cnt++;
      end
      `CHK(cnt, 5)
   endtask : t_cdr

   task t_freeze;
      logic [3:0] held;
      held = pv();
      ce <= 1'b0;
      pin(8'h00);
      `CHK(pv(), held)
      ce <= 1'b1;
      settle();
      `CHK(pv(), MAP[3:0])
      presetn <= 1'b0;
      @(posedge pclk);
      `CHK({ctl.power_save, ctl.sel_trace, lock_n_oe}, 3'b100)
      presetn <= 1'b1;
      settle();
      `CHK(pv(), MAP[3:0])
      apb(1'b0, IDX_CTRL, 32'h0);
      `CHK(rd, 32'h0)
   endtask : t_freeze

   task conclude;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      conclude();
   end

   initial begin
      t_reset();
      t_apb();
      t_pins();
      t_override();
      t_carrier();
      t_split_bypass();
      t_adapt();
      t_rate();
      t_cdr();
      t_freeze();
      conclude();
   end
endmodule : sdi_equalizer_mode_control_tb_top
`default_nettype wire
